// ---- rtl/tsb_pkg.sv ----
// Shared constants, modes and carrier structs of the touch scan and buzzer block
package tsb_pkg;
  // ==========================================================================
  // Clocking and timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int MEAS_TIME_US = 2000;                     // Sensing slot
  localparam int LED_TIME_US  = 2444;                     // LED drive slot, frame ~40 ms
  localparam int MEAS_CYC_DEF = MEAS_TIME_US * (CLK_HZ / 1_000_000);
  localparam int LED_CYC_DEF  = LED_TIME_US * (CLK_HZ / 1_000_000);
  localparam int MS_CYC_DEF   = CLK_HZ / 1000;            // One millisecond
  localparam int TONE_HZ_BASE = 1000;                     // Lowest buzzer tone
  localparam int TONE_HALF_DEF = CLK_HZ / (2 * TONE_HZ_BASE);
  localparam int PWM_HZ       = 2_000_000;
  localparam int PWM_DIV      = CLK_HZ / PWM_HZ;          // 10 cycles per PWM tick

  // ==========================================================================
  // Frame layout and limits
  localparam int           NUM_BTN      = 8;
  localparam logic [3:0]   PROX_SLOT    = 4'h8;           // Ninth slot: combined sensing
  localparam logic [4:0]   BUZZ_LEN_MIN = 5'h05;          // 5 ms
  localparam logic [4:0]   BUZZ_LEN_MAX = 5'h1e;          // 30 ms
  localparam logic [5:0]   PWM_LAST     = 6'h3f;

  // ==========================================================================
  // State encodings
  typedef enum logic [1:0] {SQ_MEAS = 2'b01, SQ_LED = 2'b10} tsb_seq_t;
  typedef enum logic [2:0] {BZ_IDLE = 3'b001, BZ_PH1 = 3'b010, BZ_PH2 = 3'b100} tsb_bz_t;

  // ==========================================================================
  // Configuration carriers
  typedef struct packed {
    logic [15:0] thresh;
    logic [15:0] hyst;
  } tsb_det_cfg_t;

  typedef struct packed {
    logic       en;
    logic       idle;
    logic [1:0] freq1;                                    // 0:1k 1:2k 2:4k 3:8k
    logic [1:0] freq2;
    logic [4:0] len1;                                     // Milliseconds
    logic [4:0] len2;
  } tsb_buzz_cfg_t;

  typedef struct packed {
    logic [7:0]      map;                                 // 0: first output, 1: second
    logic [7:0][5:0] level;
    logic [5:0]      idle1;
    logic [5:0]      idle2;
  } tsb_aoi_cfg_t;

  // ==========================================================================
  // Complete state of the top module
  typedef struct packed {
    tsb_seq_t        seq;
    logic [3:0]      slot;
    logic [19:0]     tmr;
    logic [3:0]      frame_idx;
    logic            sleep;
    logic            touched_seen;
    logic [7:0]      touched;
    logic            prox;
    logic            meas_req;
    logic [3:0]      meas_ch;
    logic            frame_done;
    tsb_bz_t         bz;
    logic [14:0]     ms_cnt;
    logic [4:0]      ms_left;
    logic [13:0]     tone_cnt;
    logic            tone;
    logic [3:0]      pwm_div;
    logic [5:0]      pwm_cnt;
    logic [1:0]      rep_valid;
    logic [1:0][2:0] rep_idx;
    logic            special_output_one;
    logic            special_output_two;
  } tsb_state_t;
endpackage : tsb_pkg

// ---- rtl/tsb_top.sv ----
// Scan sequencer, touch detection, mode control, buzzer and PWM level outputs
`timescale 1ns/1ps

// Behaviour
// - Level outputs are full-swing digital PWM whose duty sets the filtered voltage.
// - Two level outputs; each button maps to one, with its own level.
// - Buzzer on second output plays two phases, each 5 to 30 ms.
// - Buzzer tones of 1, 2, 4 or 8 kHz, chosen by configuration.
// - Configuration may be read and written any number of times.
// - Configuration comes each boot from host writes or from nonvolatile store.
// - Host writes may still overwrite stored settings, in part or whole.
// - Channels sensed round robin with an LED drive slot after each.
// - A frame is eight button slots followed by one proximity slot.
// - All nine slots always run, even when disabled or unsupported.
// - Skip frames drop sensing but keep LED timing; period grows accordingly.
// - Active mode scans every enabled sensor, about 40 ms period by default.
// - Sleep mode uses a longer period, about 200 ms; both configurable.
// - With sleep enabled, an idle frame moves Active to Sleep.
// - Any touch or proximity returns Sleep to Active.
// - Host may force the mode; the device then obeys it.
// - Proximity slot senses all sensors tied together in one cycle.
// - Touch at threshold plus hysteresis; release below threshold minus hysteresis.
// - Proximity uses the same two-state hysteresis detection.
// - Default buzz is two 5 ms phases at 1 kHz.
// - Buzzer sounds once per touch, never again while held.
// - Buzzer enable, idle level, frequencies and durations are configurable.
// - Level PWM has 6-bit resolution clocked at 2 MHz.
module tsb_top import tsb_pkg::*; #(
  parameter int MEAS_CYC      = MEAS_CYC_DEF,
  parameter int LED_CYC       = LED_CYC_DEF,
  parameter int MS_CYC        = MS_CYC_DEF,
  parameter int TONE_HALF_CYC = TONE_HALF_DEF
) (
  input  wire logic          REF_CLK,
  input  wire logic          RST,
  input  wire logic [7:0]    CH_EN,
  input  wire logic          PROX_EN,
  input  wire logic          SLEEP_EN,
  input  wire logic          FORCE_EN,
  input  wire logic          FORCE_SLEEP,
  input  wire logic [3:0]    ACT_SKIP,
  input  wire logic [3:0]    SLEEP_SKIP,
  input  wire tsb_det_cfg_t  DET_CFG,
  input  wire tsb_buzz_cfg_t BUZZ_CFG,
  input  wire tsb_aoi_cfg_t  AOI_CFG,
  input  wire logic          SENSE_VALID,
  input  wire logic [15:0]   SENSE_DATA,
  output logic               MEAS_REQ,
  output logic [3:0]         MEAS_CH,
  output logic               LED_PERIOD,
  output logic               FRAME_DONE,
  output logic               SLEEP_MODE,
  output logic [7:0]         BTN_TOUCHED,
  output logic               PROX_ON,
  output logic               SPECIAL_OUTPUT_ONE,
  output logic               SPECIAL_OUTPUT_TWO
);

  // ==========================================================================
  // State registers
  tsb_state_t s_reg;
  tsb_state_t s_next;
  // Combinational helpers
  logic [15:0] on_lvl;
  logic [15:0] off_lvl;
  logic        slot_end;
  logic        frame_end;
  logic [7:0]  new_touch;
  logic        activity;
  logic [3:0]  skip_n;
  logic [4:0]  len_sel;
  logic [1:0]  frq_sel;
  logic [13:0] half_cyc;
  logic [5:0]  duty;

  // Hysteresis bounds, release bound clamped at zero
  assign on_lvl  = DET_CFG.thresh + DET_CFG.hyst;
  assign off_lvl = (DET_CFG.thresh > DET_CFG.hyst) ? DET_CFG.thresh - DET_CFG.hyst : 16'h0000;

  // Live configuration ports are honoured every cycle, whatever loaded them
  assign skip_n = s_reg.sleep ? SLEEP_SKIP : ACT_SKIP;

  assign slot_end  = (s_reg.tmr == 20'(((s_reg.seq == SQ_MEAS) ? MEAS_CYC : LED_CYC) - 1));
  assign frame_end = slot_end && (s_reg.seq == SQ_LED) && (s_reg.slot == PROX_SLOT);

  // ==========================================================================
  // Next-state logic
  always_comb begin
    s_next      = s_reg;
    new_touch   = 8'h00;
    activity    = 1'b0;
    len_sel     = 5'h00;
    frq_sel     = 2'h0;
    half_cyc    = 14'h0000;
    duty        = 6'h00;
    s_next.meas_req   = 1'b0;
    s_next.frame_done = 1'b0;

    // Slot sequencer: sense slot then LED slot, nine pairs per frame
    s_next.tmr = slot_end ? 20'h00000 : s_reg.tmr + 20'h00001;
    if (slot_end) begin
      case (s_reg.seq)
        SQ_MEAS: s_next.seq = SQ_LED;
        SQ_LED: begin
          s_next.seq  = SQ_MEAS;
          s_next.slot = (s_reg.slot == PROX_SLOT) ? 4'h0 : s_reg.slot + 4'h1;
        end
        default: s_next.seq = SQ_MEAS;
      endcase
    end
    // Sense request at slot start, only in a measuring frame and enabled slot
    if (slot_end && s_reg.seq == SQ_LED && s_reg.frame_idx == 4'h0 && !frame_end) begin
      s_next.meas_req = (s_next.slot == PROX_SLOT) ? PROX_EN : CH_EN[s_next.slot[2:0]];
      s_next.meas_ch  = s_next.slot;
    end
    if (frame_end) begin
      s_next.frame_done = 1'b1;
      s_next.frame_idx  = (s_reg.frame_idx >= skip_n) ? 4'h0 : s_reg.frame_idx + 4'h1;
      s_next.meas_req   = (s_next.frame_idx == 4'h0) && CH_EN[0];
      s_next.meas_ch    = 4'h0;
    end

    // Touch and proximity detection with hysteresis
    if (SENSE_VALID && s_reg.seq == SQ_MEAS) begin
      if (s_reg.slot == PROX_SLOT) begin
        if (!s_reg.prox && SENSE_DATA >= on_lvl) s_next.prox = 1'b1;
        else if (s_reg.prox && SENSE_DATA < off_lvl) s_next.prox = 1'b0;
      end else begin
        if (!s_reg.touched[s_reg.slot[2:0]] && SENSE_DATA >= on_lvl)
          s_next.touched[s_reg.slot[2:0]] = 1'b1;
        else if (s_reg.touched[s_reg.slot[2:0]] && SENSE_DATA < off_lvl)
          s_next.touched[s_reg.slot[2:0]] = 1'b0;
      end
    end
    s_next.touched = s_next.touched & CH_EN;
    s_next.prox    = s_next.prox & PROX_EN;
    new_touch = s_next.touched & ~s_reg.touched;
    activity  = (|s_next.touched) || s_next.prox;

    // Operating mode
    s_next.touched_seen = activity || (!frame_end && s_reg.touched_seen);  // Activity wins over the clear
    if (FORCE_EN) begin
      if (frame_end) s_next.sleep = FORCE_SLEEP;
    end else if (s_reg.sleep && activity) begin
      s_next.sleep = 1'b0;
    end else if (frame_end && SLEEP_EN && !s_reg.touched_seen && !activity) begin
      s_next.sleep = 1'b1;
    end

    // Buzzer: two timed phases of square wave
    s_next.ms_cnt = (s_reg.ms_cnt == 15'(MS_CYC - 1)) ? 15'h0000 : s_reg.ms_cnt + 15'h0001;
    frq_sel  = (s_reg.bz == BZ_PH2) ? BUZZ_CFG.freq2 : BUZZ_CFG.freq1;
    half_cyc = 14'(TONE_HALF_CYC) >> frq_sel;
    case (s_reg.bz)
      BZ_IDLE: begin
        s_next.tone = BUZZ_CFG.idle;
        if (BUZZ_CFG.en && |new_touch) begin
          len_sel          = BUZZ_CFG.len1;
          s_next.bz        = BZ_PH1;
          s_next.ms_cnt    = 15'h0000;
          s_next.tone_cnt  = 14'h0000;
          s_next.tone      = ~BUZZ_CFG.idle;
          s_next.ms_left   = (len_sel < BUZZ_LEN_MIN) ? BUZZ_LEN_MIN :
                             (len_sel > BUZZ_LEN_MAX) ? BUZZ_LEN_MAX : len_sel;
        end
      end
      BZ_PH1, BZ_PH2: begin
        if (s_reg.tone_cnt >= half_cyc - 14'h0001) begin
          s_next.tone_cnt = 14'h0000;
          s_next.tone     = ~s_reg.tone;
        end else begin
          s_next.tone_cnt = s_reg.tone_cnt + 14'h0001;
        end
        if (s_reg.ms_cnt == 15'(MS_CYC - 1)) begin
          s_next.ms_left = s_reg.ms_left - 5'h01;
          if (s_reg.ms_left == 5'h01) begin
            if (s_reg.bz == BZ_PH1) begin
              len_sel         = BUZZ_CFG.len2;
              s_next.bz       = BZ_PH2;
              s_next.tone_cnt = 14'h0000;
              s_next.ms_left  = (len_sel < BUZZ_LEN_MIN) ? BUZZ_LEN_MIN :
                                (len_sel > BUZZ_LEN_MAX) ? BUZZ_LEN_MAX : len_sel;
            end else begin
              s_next.bz   = BZ_IDLE;
              s_next.tone = BUZZ_CFG.idle;
            end
          end
        end
        if (!BUZZ_CFG.en) begin
          s_next.bz   = BZ_IDLE;
          s_next.tone = BUZZ_CFG.idle;
        end
      end
      default: s_next.bz = BZ_IDLE;
    endcase

    // 6-bit PWM stepped at 2 MHz
    s_next.pwm_div = (s_reg.pwm_div == 4'(PWM_DIV - 1)) ? 4'h0 : s_reg.pwm_div + 4'h1;
    if (s_reg.pwm_div == 4'(PWM_DIV - 1)) s_next.pwm_cnt = s_reg.pwm_cnt + 6'h01;

    // Report one button per output: keep current while held, else lowest index
    for (int o = 0; o < 2; o++) begin
      if (!(s_reg.rep_valid[o] && s_reg.touched[s_reg.rep_idx[o]])) begin
        s_next.rep_valid[o] = 1'b0;
        for (int b = NUM_BTN - 1; b >= 0; b--) begin
          if (s_reg.touched[b] && (AOI_CFG.map[b] == o[0])) begin
            s_next.rep_valid[o] = 1'b1;
            s_next.rep_idx[o]   = 3'(b);
          end
        end
      end
    end

    // Registered PWM compare drives output one, and output two while the buzzer is disabled, rail to rail
    duty = s_reg.rep_valid[0] ? AOI_CFG.level[s_reg.rep_idx[0]] : AOI_CFG.idle1;
    s_next.special_output_one = (s_reg.pwm_cnt < duty);
    duty = s_reg.rep_valid[1] ? AOI_CFG.level[s_reg.rep_idx[1]] : AOI_CFG.idle2;
    s_next.special_output_two = BUZZ_CFG.en ? s_next.tone : (s_reg.pwm_cnt < duty);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s_reg     <= '0;
      s_reg.seq <= SQ_MEAS;
      s_reg.bz  <= BZ_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state flip-flops
  assign MEAS_REQ           = s_reg.meas_req;
  assign MEAS_CH            = s_reg.meas_ch;
  assign LED_PERIOD         = s_reg.seq[1];                        // One-hot LED bit
  assign FRAME_DONE         = s_reg.frame_done;
  assign SLEEP_MODE         = s_reg.sleep;
  assign BTN_TOUCHED        = s_reg.touched;
  assign PROX_ON            = s_reg.prox;
  assign SPECIAL_OUTPUT_ONE = s_reg.special_output_one;
  assign SPECIAL_OUTPUT_TWO = s_reg.special_output_two;

  // ==========================================================================
  // Assertions
  // One clock and one reset for every check below
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // Sequencer checks
  a_frame_wrap: assert property (frame_end |=> s_reg.slot == 4'h0 && s_reg.seq == SQ_MEAS)
    else $error("frame did not wrap to slot zero");
  a_led_follows: assert property (slot_end && s_reg.seq == SQ_MEAS |=> LED_PERIOD)
    else $error("sense slot not followed by LED slot");
  a_skip_quiet: assert property (MEAS_REQ |-> s_reg.frame_idx == 4'h0)
    else $error("sense request inside skip frame");
  a_req_enabled: assert property (
      MEAS_REQ && MEAS_CH != PROX_SLOT |-> |($past(CH_EN) & (8'h01 << MEAS_CH[2:0])))
    else $error("sense request for disabled channel");

  // Detection checks
  a_touch_on: assert property (
      SENSE_VALID && s_reg.seq == SQ_MEAS && s_reg.slot < PROX_SLOT && CH_EN[s_reg.slot[2:0]]
      && SENSE_DATA >= on_lvl |=> BTN_TOUCHED[$past(s_reg.slot[2:0])])
    else $error("touch not set at threshold plus hysteresis");
  a_touch_off: assert property (
      SENSE_VALID && s_reg.seq == SQ_MEAS && s_reg.slot < PROX_SLOT && BTN_TOUCHED[s_reg.slot[2:0]]
      && SENSE_DATA < off_lvl |=> !BTN_TOUCHED[$past(s_reg.slot[2:0])])
    else $error("touch not released below lower bound");
  a_prox_on: assert property (
      SENSE_VALID && s_reg.seq == SQ_MEAS && s_reg.slot == PROX_SLOT && PROX_EN
      && SENSE_DATA >= on_lvl |=> PROX_ON)
    else $error("proximity not set at upper bound");
  a_prox_off: assert property (
      SENSE_VALID && s_reg.seq == SQ_MEAS && s_reg.slot == PROX_SLOT
      && PROX_ON && SENSE_DATA < off_lvl |=> !PROX_ON)
    else $error("proximity not released below lower bound");

  // Mode checks
  a_wake_up: assert property (!FORCE_EN && SLEEP_MODE && |new_touch |=> !SLEEP_MODE)
    else $error("touch did not wake from sleep");
  a_force_mode: assert property (FORCE_EN && frame_end |=> SLEEP_MODE == $past(FORCE_SLEEP))
    else $error("forced mode not obeyed");
  a_auto_sleep: assert property (
      !FORCE_EN && SLEEP_EN && frame_end && !s_reg.touched_seen && !activity |=> SLEEP_MODE)
    else $error("idle frame did not enter sleep");

  // Buzzer and level checks
  a_buzz_once: assert property (
      s_reg.bz == BZ_IDLE && $past(s_reg.bz) != BZ_IDLE && new_touch == 8'h00 |=> s_reg.bz == BZ_IDLE)
    else $error("buzzer retriggered without new touch");
  a_buzz_idle: assert property (
      BUZZ_CFG.en && s_reg.bz == BZ_IDLE && new_touch == 8'h00 |=> SPECIAL_OUTPUT_TWO == $past(BUZZ_CFG.idle))
    else $error("idle buzzer output not at idle level");
  a_buzz_len: assert property (
      s_reg.bz != BZ_IDLE |-> s_reg.ms_left != 5'h00 && s_reg.ms_left <= BUZZ_LEN_MAX)
    else $error("buzzer phase length out of range");
  a_pwm_full: assert property (
      !BUZZ_CFG.en && !s_reg.rep_valid[1] && AOI_CFG.idle2 == 6'h00 |=> !SPECIAL_OUTPUT_TWO)
    else $error("zero duty output not low");
  a_pwm_tick: assert property (s_reg.pwm_div == 4'h0 |-> ##(PWM_DIV - 1) s_reg.pwm_div == 4'(PWM_DIV - 1))
    else $error("pwm tick period wrong");

  c_frame: cover property (frame_end);
  c_buzz_two: cover property (s_reg.bz == BZ_PH1 ##1 s_reg.bz == BZ_PH2);
  c_sleep_wake: cover property (SLEEP_MODE ##1 !SLEEP_MODE);
  c_prox_on: cover property (!PROX_ON ##1 PROX_ON);
  c_skip_frame: cover property (frame_end && s_reg.frame_idx != 4'h0);

endmodule : tsb_top

// ---- sim/tsb_fe_model.sv ----
// Sensing front-end model that answers each sensing request with a stored value
`timescale 1ns/1ps
module tsb_fe_model import tsb_pkg::*; (
  input  wire logic             clk,
  input  wire logic             meas_req,
  input  wire logic [3:0]       meas_ch,
  input  wire logic [3:0]       dly,
  input  wire logic [8:0][15:0] vals,
  output logic                  sense_valid = 1'b0,
  output logic [15:0]           sense_data = 16'h0000
);
  logic        busy_reg = 1'b0;
  logic [3:0]  cnt_reg  = 4'h0;
  logic [15:0] last_reg = 16'h0000;

  // ==========================================================================
  // Answer dly plus one cycles after a request; between answers the data is inverted
  always_ff @(posedge clk) begin
    sense_valid <= 1'b0;
    sense_data  <= ~last_reg;
    if (meas_req) begin
      busy_reg <= 1'b1;
      cnt_reg  <= dly;
    end else if (busy_reg && cnt_reg == 4'h0) begin
      busy_reg    <= 1'b0;
      sense_valid <= 1'b1;
      sense_data  <= vals[meas_ch];
      last_reg    <= vals[meas_ch];
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule : tsb_fe_model

// ---- sim/touch_scan_buzzer_control_test.sv ----
// Self-checking bench of the touch scan, mode, buzzer and level outputs
`timescale 1ns/1ps
module touch_scan_buzzer_control_test import tsb_pkg::*;;
  localparam int MC = 20;
  localparam int LC = 20;
  localparam int MS = 40;
  localparam int TH = 8;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] ch_en = 8'hff;
  logic prox_en = 1'b1, sleep_en = 1'b0, force_en = 1'b0, force_sleep = 1'b0;
  logic [3:0] act_skip = 4'h0, sleep_skip = 4'h0, dly = 4'h3;
  tsb_det_cfg_t det = '{thresh: 16'h0064, hyst: 16'h000a};
  tsb_buzz_cfg_t bz = '{1'b1, 1'b0, 2'h0, 2'h0, 5'h05, 5'h05};
  tsb_aoi_cfg_t level_output_interface = '0;
  logic [8:0][15:0] vals = '0;
  logic sv, mreq, ledp, fdone, slp, prox, o1, o2;
  logic [15:0] sd;
  logic [3:0] mch;
  logic [7:0] btn;
  int err_count = 0, comparisons = 0, waited, wch, n1, n2;

  tsb_top #(.MEAS_CYC(MC), .LED_CYC(LC), .MS_CYC(MS), .TONE_HALF_CYC(TH)) u_tsb_top (
    .REF_CLK(ref_clk), .RST(rst), .CH_EN(ch_en), .PROX_EN(prox_en), .SLEEP_EN(sleep_en),
    .FORCE_EN(force_en), .FORCE_SLEEP(force_sleep), .ACT_SKIP(act_skip), .SLEEP_SKIP(sleep_skip),
    .DET_CFG(det), .BUZZ_CFG(bz), .AOI_CFG(level_output_interface), .SENSE_VALID(sv), .SENSE_DATA(sd),
    .MEAS_REQ(mreq), .MEAS_CH(mch), .LED_PERIOD(ledp), .FRAME_DONE(fdone), .SLEEP_MODE(slp),
    .BTN_TOUCHED(btn), .PROX_ON(prox), .SPECIAL_OUTPUT_ONE(o1), .SPECIAL_OUTPUT_TWO(o2));
  tsb_fe_model u_tsb_fe_model (.clk(ref_clk), .meas_req(mreq), .meas_ch(mch), .dly(dly),
    .vals(vals), .sense_valid(sv), .sense_data(sd));

  // ==========================================================================
  // Clock and shared helpers
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  function automatic logic cond(input int sel);
    case (sel)
      0: return mreq === 1'b1;
      1: return fdone === 1'b1;
      2: return btn[wch] === 1'b1;
      3: return btn[wch] === 1'b0;
      4: return slp === 1'b1;
      5: return o2 !== bz.idle;
      default: return o2 === bz.idle;
    endcase
  endfunction : cond
  // Bounded wait; waited holds the cycles spent
  task automatic wait_until(input int sel, input int lim);
    waited = 0;
    do begin
      @(negedge ref_clk);
      waited++;
    end while (!cond(sel) && waited < lim);
    if (!cond(sel)) begin
      $display("[ERR] %0t wait %0d ran out", $time, sel);
      err_count++;
      tally_and_finish();
    end
  endtask : wait_until
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Scenarios
  task automatic t_frame();
    logic [3:0] ch;
    wait_until(0, 100);
    for (int k = 0; k < 10; k++) begin
      ch = mch;
      cyc(10);
      chk(ledp, 1'b0);
      cyc(20);
      chk(ledp, 1'b1);
      wait_until(0, 100);
      chk(waited, 10);
      chk(mch, (ch == 4'h8) ? 4'h0 : ch + 4'h1);
    end
    wait_until(1, 400);
    wait_until(1, 400);
    chk(waited, 9 * (MC + LC));
    $display("test frame done");
  endtask : t_frame
  task automatic t_touch();
    wch = 2;
    vals[2] = 16'h006e;
    vals[3] = 16'h006d;
    vals[8] = 16'h006e;
    wait_until(2, 800);
    cyc(720);
    chk(btn[3], 1'b0);
    chk(prox, 1'b1);
    vals[2] = 16'h005a;
    vals[8] = 16'h0059;
    cyc(720);
    chk(btn[2], 1'b1);
    chk(prox, 1'b0);
    vals[2] = 16'h0059;
    vals[3] = 16'h0000;
    wait_until(3, 800);
    $display("test touch done");
  endtask : t_touch
  task automatic t_buzz();
    for (int f = 0; f < 4; f++) begin
      bz.freq1 = f[1:0];
      bz.idle = f[1];
      cyc(5);
      wch = 0;
      vals[0] = 16'h00c8;
      wait_until(2, 800);
      wait_until(5, 4);
      wait_until(6, 20);
      wait_until(5, 20);
      chk(waited, TH >> f);
      n1 = 0;
      n2 = 0;
      for (int i = 0; i < 1130; i++) begin
        @(negedge ref_clk);
        if (o2 !== bz.idle && i < 410) n1++;
        if (o2 !== bz.idle && i >= 410) n2++;
      end
      chk(n1 >= 150 && n1 <= 205, 1'b1);
      chk(n2, 0);
      vals[0] = 16'h0000;
      wait_until(3, 800);
    end
    $display("test buzz done");
  endtask : t_buzz
  task automatic t_level(input int exp1, input int exp2);
    n1 = 0;
    n2 = 0;
    for (int i = 0; i < 640; i++) begin
      @(negedge ref_clk);
      n1 += int'(o1 === 1'b1);
      n2 += int'(o2 === 1'b1);
    end
    chk(n1, exp1);
    chk(n2, exp2);
  endtask : t_level
  task automatic t_pwm();
    bz.en = 1'b0;
    level_output_interface.map = 8'h80;
    level_output_interface.idle1 = 6'h10;
    level_output_interface.idle2 = 6'h30;
    level_output_interface.level[1] = 6'h0c;
    level_output_interface.level[7] = 6'h24;
    cyc(20);
    t_level(160, 480);
    vals[1] = 16'h00c8;
    vals[7] = 16'h00c8;
    wch = 7;
    wait_until(2, 800);
    wch = 1;
    wait_until(2, 800);
    cyc(4);
    t_level(120, 360);
    vals[1] = 16'h0000;
    vals[7] = 16'h0000;
    wait_until(3, 800);
    wch = 7;
    wait_until(3, 800);
    level_output_interface.idle2 = 6'h00;
    cyc(4);
    t_level(160, 0);
    $display("test level done");
  endtask : t_pwm
  task automatic t_sleep();
    sleep_en = 1'b1;
    wait_until(4, 800);
    wch = 4;
    vals[4] = 16'h00c8;
    wait_until(2, 800);
    chk(slp, 1'b0);
    force_en = 1'b1;
    force_sleep = 1'b1;
    wait_until(1, 400);
    cyc(2);
    chk(slp, 1'b1);
    force_sleep = 1'b0;
    vals[4] = 16'h0000;
    cyc(1000);
    chk(slp, 1'b0);
    force_en = 1'b0;
    sleep_en = 1'b0;
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_skip();
    act_skip = 4'h1;
    wait_until(1, 800);
    wait_until(1, 800);
    do wait_until(0, 800); while (mch !== 4'h0);
    n1 = 0;
    for (int i = 0; i < 720; i++) begin
      @(negedge ref_clk);
      n1 += int'(mreq === 1'b1);
    end
    chk(n1, 9);
    chk(mch, 4'h0);
    act_skip = 4'h0;
    $display("test skip done");
  endtask : t_skip

  // ==========================================================================
  // Main sequence
  initial begin
    cyc(8);
    rst = 1'b0;
    t_frame();
    t_touch();
    t_buzz();
    t_pwm();
    t_sleep();
    t_skip();
    tally_and_finish();
  end
endmodule : touch_scan_buzzer_control_test
